// >>> logic/spm_port.sv
// spm_port: spi master/slave port with apb registers and interrupt
// assumes: apb master on pclk; link pins asynchronous, pads resolve enables
//
// Summary of operation
// [R1] master drives serial clock, sets bit rate
// [R2] one serial clock cycle per bit
// [R3] clock toggles only during word transfer
// [R4] slave ignores clock while select high
// [R5] launch on one edge, sample opposite
// [R6] polarity and phase bits select format
// [R7] device select input is active low
// [R8] select low as master flags multimaster error
// [R9] master drives mosi, slave receives it
// [R10] master receives miso, slave drives it
// [R11] open-drain bit makes miso open drain
// [R12] control bit five disables miso output
// [R13] only one external slave drives miso
// [R14] clock pin released at reset, boot drives high
// [R15] mosi pin released at reset, boot drives low
// [R16] master flag output may drive select
// [R17] lone master ties own select high
// [R18] error flag stops master until cleared
`timescale 1ns/10ps
module spm_port
  import spm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic serial_shift_clock_i,
  output logic serial_shift_clock_o,
  output logic serial_shift_clock_oe,
  input wire logic port_device_select_n,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe
);
  import spm_pkg::*;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [WORD_BITS-1:0] shift_in(input logic [WORD_BITS-1:0] w,
                                                    input logic b);
    shift_in = {w[WORD_BITS-2:0], b};
  endfunction
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers and edges
  // ---------------------------------------------------------------
  // every pin passes two flops before any logic reads it
  logic sck_s, sel_n_s, mosi_s, miso_s;
  logic sck_rise, sck_fall;
  spm_sync u_sync_sck (.pclk(pclk), .presetn(presetn), .en(clk_en),
                       .din(serial_shift_clock_i), .dout(sck_s));
  spm_sync u_sync_sel (.pclk(pclk), .presetn(presetn), .en(clk_en),
                       .din(port_device_select_n), .dout(sel_n_s));
  spm_sync u_sync_mosi (.pclk(pclk), .presetn(presetn), .en(clk_en),
                        .din(mosi_i), .dout(mosi_s));
  spm_sync u_sync_miso (.pclk(pclk), .presetn(presetn), .en(clk_en),
                        .din(miso_i), .dout(miso_s));
  spm_edge u_edge_sck (.pclk(pclk), .presetn(presetn), .en(clk_en),
                       .level(sck_s), .rise(sck_rise), .fall(sck_fall));

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [CTL_WIDTH-1:0] ctl_q;
  logic [ST_WIDTH-1:0] status_q, mask_q;
  logic [WORD_BITS-1:0] tx_q, rx_q, shift_q;
  logic start_q;
  spm_state_type state_q;
  logic [CNT_W-1:0] div_q, bits_q;
  logic sck_q, sck_oe_q, mosi_q, mosi_oe_q, miso_q, miso_oe_q;
  logic done_set, mm_set;

  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire setup_ph = psel & ~penable;
  wire hit_ctl = reg_hit(paddr, OFS_CONTROL);
  wire hit_st = reg_hit(paddr, OFS_STATUS);
  wire hit_mask = reg_hit(paddr, OFS_MASK);
  wire hit_tx = reg_hit(paddr, OFS_TXDATA);
  wire hit_rx = reg_hit(paddr, OFS_RXDATA);
  wire hit_pin = reg_hit(paddr, OFS_PINSTATE);
  wire addr_ok = hit_ctl | hit_st | hit_mask | hit_tx | hit_rx | hit_pin;
  // writes land only in the access phase, never at setup
  wire wr_ctl = wr_acc & hit_ctl;
  wire wr_st = wr_acc & hit_st;
  wire wr_mask = wr_acc & hit_mask;
  wire wr_tx = wr_acc & hit_tx;

  wire en_bit = ctl_q[CTL_ENABLE];
  wire is_master = en_bit & ctl_q[CTL_MASTER];
  wire cpol = ctl_q[CTL_CPOL];
  wire cpha = ctl_q[CTL_CPHA];
  wire mm_err = status_q[ST_MM_ERR];
  wire master_ok = is_master & ~mm_err; // [R18]
  wire busy = (state_q != SPM_IDLE);
  wire slave_sel = en_bit & ~ctl_q[CTL_MASTER] & ~sel_n_s; // [R4] [R7]
  // leading/trailing edge of the external clock in cpol terms
  wire sl_lead = cpol ? sck_fall : sck_rise;
  wire sl_trail = cpol ? sck_rise : sck_fall;
  // sample on leading edge when cpha=0, on trailing when cpha=1
  wire sl_sample = slave_sel & (cpha ? sl_trail : sl_lead); // [R5] [R6]
  wire sl_launch = slave_sel & (cpha ? sl_lead : sl_trail); // [R5]
  wire half_done = (div_q == HALF_BIT_CYC - CNT_W'(1));

  // ---------------------------------------------------------------
  // apb register writes
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= CTL_RESET;
      mask_q <= '0;
      tx_q <= '0;
      start_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctl) ctl_q <= pwdata[CTL_WIDTH-1:0]; // [R6]
      if (wr_mask) mask_q <= pwdata[ST_WIDTH-1:0];
      if (wr_tx) tx_q <= pwdata[WORD_BITS-1:0];
      // txdata written while busy or faulted is kept, not sent
      start_q <= wr_tx & master_ok & ~busy;
    end
  end

  // sticky status: set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else if (clk_en) begin
      status_q <= (status_q & ~(wr_st ? pwdata[ST_WIDTH-1:0] : '0)) | {mm_set, done_set};
    end
  end
  assign mm_set = is_master & ~sel_n_s; // [R8]

  // ---------------------------------------------------------------
  // master engine
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SPM_IDLE;
      div_q <= '0;
      bits_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        SPM_IDLE: begin
          div_q <= '0;
          bits_q <= '0;
          if (start_q) state_q <= SPM_LEAD; // [R3]
        end
        SPM_LEAD: begin
          // contention aborts mid word, the partial word is dropped
          if (!master_ok) state_q <= SPM_IDLE; // [R18]
          else if (half_done) begin
            div_q <= '0;
            state_q <= SPM_TRAIL;
          end else div_q <= div_q + CNT_W'(1);
        end
        SPM_TRAIL: begin
          if (!master_ok) state_q <= SPM_IDLE;
          else if (half_done) begin
            div_q <= '0;
            bits_q <= bits_q + CNT_W'(1); // [R2]
            state_q <= (bits_q == CNT_W'(WORD_BITS - 1)) ? SPM_IDLE : SPM_LEAD;
          end else div_q <= div_q + CNT_W'(1);
        end
        default: state_q <= SPM_IDLE;
      endcase
    end
  end
  wire m_lead_end = (state_q == SPM_LEAD) & half_done & master_ok;
  wire m_trail_end = (state_q == SPM_TRAIL) & half_done & master_ok;
  wire m_sample = cpha ? m_trail_end : m_lead_end; // [R5]
  wire m_shift = cpha ? m_lead_end : m_trail_end;
  wire m_last = m_trail_end & (bits_q == CNT_W'(WORD_BITS - 1));
  // ---------------------------------------------------------------
  // shift register, data path
  // ---------------------------------------------------------------
  logic [WORD_BITS-1:0] samp_q;
  logic sl_cnt_done;
  logic [CNT_W-1:0] sl_bits_q;
  // cpha=1: first leading edge opens the word, shifts nothing
  wire sl_shift = sl_launch & ~(cpha & (sl_bits_q == '0)); // [R5]
  assign sl_cnt_done = sl_sample & (sl_bits_q == CNT_W'(WORD_BITS - 1));
  assign done_set = m_last | sl_cnt_done;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= '0;
      samp_q <= '0;
      rx_q <= '0;
      sl_bits_q <= '0;
    end else if (clk_en) begin
      if (start_q) shift_q <= tx_q;
      // slave reloads the transmit word between words
      else if (slave_sel & ~busy & sl_bits_q == '0 & ~sl_sample & ~sl_launch)
        shift_q <= tx_q;
      else if (m_sample) samp_q <= shift_in(samp_q, miso_s); // [R10]
      else if (sl_sample) samp_q <= shift_in(samp_q, mosi_s); // [R9]
      if (m_shift | sl_shift) shift_q <= {shift_q[WORD_BITS-2:0], 1'b0}; // [R5]
      if (!slave_sel) sl_bits_q <= '0; // [R4]
      else if (sl_sample) sl_bits_q <= sl_cnt_done ? '0 : sl_bits_q + CNT_W'(1);
      if (m_last) rx_q <= samp_q;
      else if (sl_cnt_done) rx_q <= shift_in(samp_q, mosi_s);
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // an idle link clock rests at the polarity level
  wire sck_d = (state_q == SPM_TRAIL) ? ~cpol : cpol; // [R1] [R3]
  wire od = ctl_q[CTL_OPEN_DRAIN];
  // next bit goes out one cycle early, ahead of the master's sample edge
  wire miso_val = sl_shift ? shift_q[WORD_BITS-2] : shift_q[WORD_BITS-1]; // [R10]
  wire miso_dis = ctl_q[CTL_SLAVE_OUT_DIS]; // [R12]
  wire boot = ctl_q[CTL_BOOT_MASTER] & ~en_bit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b1;
      sck_oe_q <= 1'b0; // [R14]
      mosi_q <= 1'b0;
      mosi_oe_q <= 1'b0; // [R15]
      miso_q <= 1'b1;
      miso_oe_q <= 1'b0;
    end else if (clk_en) begin
      sck_q <= boot ? 1'b1 : sck_d; // [R14]
      sck_oe_q <= boot | master_ok; // [R1]
      mosi_q <= boot ? 1'b0 : shift_q[WORD_BITS-1]; // [R15]
      mosi_oe_q <= boot | master_ok; // [R9]
      miso_q <= od ? 1'b0 : miso_val; // [R11]
      miso_oe_q <= slave_sel & ~miso_dis & (od ? ~miso_val : 1'b1); // [R10] [R11]
    end
  end
  assign serial_shift_clock_o = sck_q;
  assign serial_shift_clock_oe = sck_oe_q;
  assign mosi_o = mosi_q;
  assign mosi_oe = mosi_oe_q;
  assign miso_o = miso_q;
  assign miso_oe = miso_oe_q;

  // ---------------------------------------------------------------
  // apb read side
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = ZERO_WORD;
    case (paddr)
      OFS_CONTROL: rd_mux[CTL_WIDTH-1:0] = ctl_q;
      OFS_STATUS: begin
        rd_mux[ST_WIDTH-1:0] = status_q;
        rd_mux[ST_BUSY] = busy;
      end
      OFS_MASK: rd_mux[ST_WIDTH-1:0] = mask_q;
      OFS_TXDATA: rd_mux[WORD_BITS-1:0] = tx_q;
      OFS_RXDATA: rd_mux[WORD_BITS-1:0] = rx_q;
      OFS_PINSTATE: rd_mux[3:0] = {miso_s, mosi_s, sel_n_s, sck_s};
      default: rd_mux = ZERO_WORD;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ZERO_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~addr_ok;
      if (setup_ph) prdata <= rd_mux;
    end
  end
  wire unused_rd = rd_acc;

  // ---------------------------------------------------------------
  // interrupt
  // ---------------------------------------------------------------
  wire irq_d = |(status_q & mask_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= irq_d;
    end
  end
endmodule

// >>> logic/spm_pkg.sv
// spm_pkg: register map, field layout and timing constants of the spi port
// assumes: 32-bit apb slave, pclk at 25 MHz
package spm_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_TXDATA = 8'h0C;
  localparam logic [7:0] OFS_RXDATA = 8'h10;
  localparam logic [7:0] OFS_PINSTATE = 8'h14;
  // ---------------------------------------------------------------
  // serial_port_control fields
  // ---------------------------------------------------------------
  localparam int CTL_ENABLE = 0;
  localparam int CTL_MASTER = 1;
  localparam int CTL_CPOL = 2;
  localparam int CTL_CPHA = 3;
  localparam int CTL_OPEN_DRAIN = 4;
  localparam int CTL_SLAVE_OUT_DIS = 5;
  localparam int CTL_BOOT_MASTER = 6;
  localparam int CTL_WIDTH = 7;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 7'h00;
  // ---------------------------------------------------------------
  // status / mask bits
  // ---------------------------------------------------------------
  localparam int ST_DONE = 0;
  localparam int ST_MM_ERR = 1;
  localparam int ST_WIDTH = 2;
  localparam int ST_BUSY = 2;
  // ---------------------------------------------------------------
  // word and timing
  // ---------------------------------------------------------------
  localparam int WORD_BITS = 8;
  localparam int CNT_W = 4;
  localparam int PCLK_MHZ = 25;
  localparam int HALF_BIT_NS = 160;
  localparam int HALF_BIT_CYC_I = (HALF_BIT_NS * PCLK_MHZ) / 1000;
  localparam logic [CNT_W-1:0] HALF_BIT_CYC = CNT_W'(HALF_BIT_CYC_I);
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {SPM_IDLE, SPM_LEAD, SPM_TRAIL} spm_state_type;
endpackage

// >>> logic/spm_sync.sv
// spm_sync: two-flop synchroniser for link pins
// assumes: input is asynchronous to pclk
`timescale 1ns/10ps
module spm_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end else if (en) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// >>> logic/spm_edge.sv
// spm_edge: finds rising and falling edges of a synchronised level
// assumes: input already passed spm_sync
`timescale 1ns/10ps
module spm_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic last_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 1'b1;
    end else if (en) begin
      last_q <= level;
    end
  end
  assign rise = en & level & ~last_q;
  assign fall = en & ~level & last_q;
endmodule

// >>> test/spm_sva.sv
// spm_sva: apb and link pin checks on the spi port
// assumes: bound to spm_port, one pclk domain
`timescale 1ns/10ps
module spm_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_shift_clock_o,
  input wire logic serial_shift_clock_oe,
  input wire logic port_device_select_n,
  input wire logic mosi_oe,
  input wire logic miso_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic sck_prev_q;
  logic [4:0] edges_q;
  logic [3:0] quiet_q;
  wire toggled = serial_shift_clock_oe && (serial_shift_clock_o != sck_prev_q);
  // -----------------------------------------------------------------
  // serial clock edge counter, cleared after a quiet gap
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_q <= 1'b1;
      edges_q <= 5'h00;
      quiet_q <= 4'h0;
    end else begin
      sck_prev_q <= serial_shift_clock_o;
      quiet_q <= toggled ? 4'h0 : (quiet_q == 4'hF ? quiet_q : quiet_q + 4'h1);
      edges_q <= toggled ? edges_q + 5'h01 : (quiet_q > 4'h6 ? 5'h00 : edges_q);
    end
  end
  sequence s_hold;
    $stable(serial_shift_clock_o)[*3];
  endsequence
  sequence s_sel_low;
    (!port_device_select_n)[*6];
  endsequence
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_sck_half_bit: assert property (toggled |=> s_hold)
    else $error("serial clock half period short");
  a_word_len: assert property (edges_q <= 5'h10)
    else $error("serial clock edges exceed one word");
  a_mosi_miso_dir: assert property (mosi_oe |-> !miso_oe)
    else $error("mosi and miso driven together");
  a_sck_miso_dir: assert property (serial_shift_clock_oe |-> !miso_oe)
    else $error("clock driver also drives miso");
  a_select_gate: assert property (port_device_select_n [*6] |-> !miso_oe)
    else $error("miso driven while not selected");
  a_mm_drop: assert property (s_sel_low |-> !serial_shift_clock_oe)
    else $error("clock driven while select low");
endmodule
bind spm_port spm_sva spm_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .serial_shift_clock_o(serial_shift_clock_o), .serial_shift_clock_oe(serial_shift_clock_oe),
  .port_device_select_n(port_device_select_n), .mosi_oe(mosi_oe), .miso_oe(miso_oe));

// >>> test/spm_peer.sv
// spm_peer: external slave, clock idle low, sample rising, shift falling
// assumes: selected by a bench flag line, miso pulled up when released
`timescale 1ns/10ps
module spm_peer #(parameter logic [7:0] REPLY = 8'h3C) (
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  output logic [7:0] got
);
  logic [7:0] tx;
  initial got = 8'h00;
  assign miso_oe = !sel_n;
  assign miso = tx[7];
  always @(negedge sel_n) tx = REPLY;
  always @(posedge sck) if (!sel_n) got = {got[6:0], mosi};
  always @(negedge sck) if (!sel_n) tx = {tx[6:0], 1'b0};
endmodule

// >>> test/testbench.sv
// testbench: drives spm_port over apb and the link pins
// assumes: spm_pkg, spm_peer and the bound checker compiled first
`timescale 1ns/10ps
module testbench;
  import spm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv_err;
  logic [7:0] paddr, peer_got, sl_got;
  logic [31:0] pwdata, prdata, rd_val;
  logic sck_o, sck_oe, sel_n, mosi_o, mosi_oe, miso_o, miso_oe;
  logic tb_sck, tb_mosi, peer_sel_n, peer_miso, peer_oe;
  int n_mismatch, samples_checked, cyc;
  wire sck_w = sck_oe ? sck_o : tb_sck;
  wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire miso_w = miso_oe ? miso_o : (peer_oe ? peer_miso : 1'b1);
  spm_port spm_port_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .serial_shift_clock_i(sck_w),
    .serial_shift_clock_o(sck_o), .serial_shift_clock_oe(sck_oe),
    .port_device_select_n(sel_n), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe));
  spm_peer spm_peer_inst (.sck(sck_w), .sel_n(peer_sel_n), .mosi(mosi_w),
    .miso(peer_miso), .miso_oe(peer_oe), .got(peer_got));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_val = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic shift_byte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      tb_sck <= 1'b0;
      tb_mosi <= b[i];
      repeat (4) @(posedge pclk);
      r = {r[6:0], miso_w};
      tb_sck <= 1'b1;
      repeat (4) @(posedge pclk);
    end
  endtask
  task automatic t_master;
    apb(1, OFS_CONTROL, 32'h03);
    apb(1, OFS_MASK, 32'h01);
    peer_sel_n <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1, OFS_TXDATA, 32'hA5);
    for (int n = 0; n < 400 && irq !== 1'b1; n++) @(posedge pclk);
    chk("peer byte", {24'h0, peer_got}, 32'hA5);
    apb(0, OFS_RXDATA, 32'h0);
    chk("master rx", rd_val & 32'hFF, 32'h3C);
    apb(0, OFS_STATUS, 32'h0);
    chk("done bit", rd_val & 32'h3, 32'h1);
    apb(1, OFS_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    peer_sel_n <= 1'b1;
  endtask
  task automatic t_mm;
    apb(1, OFS_MASK, 32'h0);
    sel_n <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1, OFS_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk("mm irq", {31'h0, irq}, 32'h1);
    apb(1, OFS_TXDATA, 32'h5A);
    repeat (8) @(posedge pclk);
    chk("mm sck oe", {31'h0, sck_oe}, 32'h0);
    apb(0, OFS_STATUS, 32'h0);
    chk("mm status", rd_val & 32'h2, 32'h2);
    sel_n <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1, OFS_STATUS, 32'h2);
    apb(0, OFS_STATUS, 32'h0);
    chk("mm cleared", rd_val & 32'h2, 32'h0);
    apb(1, OFS_MASK, 32'h0);
  endtask
  task automatic t_slave;
    apb(1, OFS_CONTROL, 32'h0D);
    apb(1, OFS_TXDATA, 32'h81);
    sel_n <= 1'b0;
    repeat (4) @(posedge pclk);
    shift_byte(8'h96, sl_got);
    chk("slave miso oe", {31'h0, miso_oe}, 32'h1);
    chk("slave miso data", {24'h0, sl_got}, 32'h81);
    sel_n <= 1'b1;
    repeat (8) @(posedge pclk);
    shift_byte(8'h0F, sl_got);
    chk("miso released", {24'h0, sl_got}, 32'hFF);
    tb_mosi <= 1'b1;
    apb(0, OFS_RXDATA, 32'h0);
    chk("slave rx", rd_val & 32'hFF, 32'h96);
    apb(1, OFS_CONTROL, 32'h2D);
    sel_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("miso disabled", {31'h0, miso_oe}, 32'h0);
    apb(1, OFS_CONTROL, 32'h1D);
    apb(1, OFS_TXDATA, 32'hFF);
    repeat (8) @(posedge pclk);
    chk("open drain high", {31'h0, miso_oe}, 32'h0);
    sel_n <= 1'b1;
  endtask
  task automatic t_boot;
    apb(1, OFS_CONTROL, 32'h40);
    repeat (3) @(posedge pclk);
    chk("boot pins", {28'h0, sck_oe, sck_o, mosi_oe, mosi_o}, 32'hE);
    apb(1, OFS_CONTROL, 32'h0);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {sel_n, tb_sck, tb_mosi, peer_sel_n} = 4'hF;
    repeat (4) @(posedge pclk);
    chk("reset oe", {29'h0, sck_oe, mosi_oe, miso_oe}, 32'h0);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_CONTROL, 32'h0);
    chk("control reset", rd_val & 32'h7F, 32'h0);
    apb(0, 8'h20, 32'h0);
    chk("unmapped err", {31'h0, slv_err}, 32'h1);
    t_master;
    t_mm;
    t_slave;
    t_boot;
    give_verdict;
  end
endmodule
